// ===== core/ptdc_pkg.sv
// Constants and types of the periodic tick down counter
// Function
// - A 24-bit counter counts down and interrupts at zero when enabled.
// - Counting runs on system clock or a half-rate reference clock.
// - Clock select bit at 1 counts on the system clock.
// - On expiry the counter reloads from the reload register, repeating forever.
// - One period spans reload plus one counter clocks.
// - Calibration register resets to 0x4 and is writable.
// - Any write to the current value register clears the counter.
// - Writing 0x7 to control enables counter, interrupt and system clock.
// - Control, reload and current value reset to zero, counter disabled.
package ptdc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_CONTROL_STATUS = 32'hE000E010;
    localparam logic [31:0] ADDR_RELOAD_VALUE = 32'hE000E014;
    localparam logic [31:0] ADDR_CURRENT_VALUE = 32'hE000E018;
    localparam logic [31:0] ADDR_CALIBRATION_VALUE = 32'h0E000E1C;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hE000E020;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hE000E024;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int COUNT_W = 24;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_TICK_INT = 1;
    localparam int BIT_CLK_SEL = 2;
    localparam int BIT_COUNT_FLAG = 16;
    localparam int BIT_IRQ_ZERO = 0;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] RST_CALIBRATION = 32'h00000004;
    localparam logic [23:0] RST_COUNT = 24'h000000;
    localparam logic RST_IRQ_MASK = 1'b1;
    localparam logic [0:0] REF_DIV_LAST = 1'h1;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic tick_int;
        logic clk_sel;
        logic count_flag;
        logic [COUNT_W-1:0] reload;
        logic [COUNT_W-1:0] current;
        logic [31:0] calib;
        logic irq_status;
        logic irq_mask;
        logic [31:0] rdata;
    } ptdc_state_s;

    typedef struct packed {
        logic [0:0] phase;
        logic ref_tick;
    } ptdc_gen_s;

endpackage : ptdc_pkg

// ===== core/ptdc_tick_if.sv
// Count clock enables passed from the tick generator to the counter
`timescale 1ns/1ns
interface ptdc_tick_if;
    logic sys_tick;
    logic ref_tick;
    modport src (output sys_tick, output ref_tick);
    modport sink (input sys_tick, input ref_tick);
endinterface : ptdc_tick_if

// ===== core/ptdc_tick_gen.sv
// Tick enable generator: system rate and half-rate reference
`timescale 1ns/1ns
module ptdc_tick_gen (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Tick enables
    ptdc_tick_if.src tick
);
    ptdc_pkg::ptdc_gen_s st;
    ptdc_pkg::ptdc_gen_s next_st;

    always_comb begin
        next_st = st;
        next_st.phase = st.phase + 1'h1;
        next_st.ref_tick = (st.phase == ptdc_pkg::REF_DIV_LAST);
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick.sys_tick = 1'b1;
    assign tick.ref_tick = st.ref_tick;

    AST_REF_ALTERNATES: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st.ref_tick |=> !st.ref_tick ##1 st.ref_tick)
        else $error("Reference tick is not half rate");

endmodule : ptdc_tick_gen

// ===== core/ptdc_top.sv
// Periodic tick down counter with register port and interrupt
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module ptdc_top (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_NRST,
    // Register port
    input wire logic [31:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // Interrupt
    output logic O_IRQ
);

    // ------------------------------------------------------------
    // Tick source
    // ------------------------------------------------------------
    ptdc_tick_if tick_bus ();

    ptdc_tick_gen u_tick_gen (
        .i_mclk(I_MCLK),
        .i_nrst(I_NRST),
        .tick(tick_bus.src)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
        hit = (addr == offset);
    endfunction : hit

    ptdc_pkg::ptdc_state_s st;
    ptdc_pkg::ptdc_state_s next_st;

    logic wr_csr;
    logic wr_rvr;
    logic wr_cvr;
    logic wr_cal;
    logic wr_msk;
    logic rd_csr;
    logic rd_sts;
    logic cnt_tick;
    logic zero_evt;

    assign wr_csr = I_WR && hit(I_ADDR, ptdc_pkg::ADDR_CONTROL_STATUS);
    assign wr_rvr = I_WR && hit(I_ADDR, ptdc_pkg::ADDR_RELOAD_VALUE);
    assign wr_cvr = I_WR && hit(I_ADDR, ptdc_pkg::ADDR_CURRENT_VALUE);
    assign wr_cal = I_WR && hit(I_ADDR, ptdc_pkg::ADDR_CALIBRATION_VALUE);
    assign wr_msk = I_WR && hit(I_ADDR, ptdc_pkg::ADDR_IRQ_MASK);
    assign rd_csr = I_RD && hit(I_ADDR, ptdc_pkg::ADDR_CONTROL_STATUS);
    assign rd_sts = I_RD && hit(I_ADDR, ptdc_pkg::ADDR_IRQ_STATUS);

    // ------------------------------------------------------------
    // Count enable and expiry
    // ------------------------------------------------------------
    assign cnt_tick = st.enable && (st.clk_sel ? tick_bus.sys_tick : tick_bus.ref_tick);
    assign zero_evt = cnt_tick && !wr_cvr && (st.current == 24'h000001);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h00000000;
        if (wr_csr) begin
            next_st.enable = I_WDATA[ptdc_pkg::BIT_ENABLE];
            next_st.tick_int = I_WDATA[ptdc_pkg::BIT_TICK_INT];
            next_st.clk_sel = I_WDATA[ptdc_pkg::BIT_CLK_SEL];
        end
        if (wr_rvr) begin
            next_st.reload = I_WDATA[ptdc_pkg::COUNT_W-1:0];
        end
        if (wr_cal) begin
            next_st.calib = I_WDATA;
        end
        if (wr_msk) begin
            next_st.irq_mask = I_WDATA[ptdc_pkg::BIT_IRQ_ZERO];
        end
        if (wr_cvr) begin
            next_st.current = ptdc_pkg::RST_COUNT;
        end else if (cnt_tick) begin
            if (st.current == ptdc_pkg::RST_COUNT) begin
                next_st.current = st.reload;
            end else begin
                next_st.current = st.current - 24'h000001;
            end
        end
        // Set wins over a read clear; a current value write blocks the set
        next_st.count_flag = zero_evt || (st.count_flag && !rd_csr && !wr_cvr);
        next_st.irq_status = (zero_evt && st.tick_int) || (st.irq_status && !rd_sts);
        if (I_RD) begin
            case (I_ADDR)
                ptdc_pkg::ADDR_CONTROL_STATUS: begin
                    next_st.rdata[ptdc_pkg::BIT_ENABLE] = st.enable;
                    next_st.rdata[ptdc_pkg::BIT_TICK_INT] = st.tick_int;
                    next_st.rdata[ptdc_pkg::BIT_CLK_SEL] = st.clk_sel;
                    next_st.rdata[ptdc_pkg::BIT_COUNT_FLAG] = st.count_flag;
                end
                ptdc_pkg::ADDR_RELOAD_VALUE: begin
                    next_st.rdata[ptdc_pkg::COUNT_W-1:0] = st.reload;
                end
                ptdc_pkg::ADDR_CURRENT_VALUE: begin
                    next_st.rdata[ptdc_pkg::COUNT_W-1:0] = st.current;
                end
                ptdc_pkg::ADDR_CALIBRATION_VALUE: begin
                    next_st.rdata = st.calib;
                end
                ptdc_pkg::ADDR_IRQ_STATUS: begin
                    next_st.rdata[ptdc_pkg::BIT_IRQ_ZERO] = st.irq_status;
                end
                ptdc_pkg::ADDR_IRQ_MASK: begin
                    next_st.rdata[ptdc_pkg::BIT_IRQ_ZERO] = st.irq_mask;
                end
                default: begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st <= '0;
            st.calib <= ptdc_pkg::RST_CALIBRATION;
            st.irq_mask <= ptdc_pkg::RST_IRQ_MASK;
        end else begin
            st <= next_st;
        end
    end

    assign O_RDATA = st.rdata;
    assign O_IRQ = st.irq_status && st.irq_mask;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_ZERO_SETS_FLAG: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        zero_evt |=> st.count_flag && st.current == 24'h000000)
        else $error("Count flag not set on reaching zero");

    AST_FLAG_READ_CLEARS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (rd_csr && !zero_evt) |=> !st.count_flag && O_RDATA[ptdc_pkg::BIT_COUNT_FLAG] == $past(st.count_flag))
        else $error("Control read does not clear count flag");

    AST_RELOAD_AT_ZERO: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (cnt_tick && !wr_cvr && st.current == 24'h000000) |=> st.current == $past(st.reload))
        else $error("Counter did not reload at expiry");

    AST_DECREMENT: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (cnt_tick && !wr_cvr && st.current != 24'h000000) |=> st.current == $past(st.current) - 24'h000001)
        else $error("Counter did not decrement");

    AST_PERIOD_TWO: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (zero_evt && st.clk_sel && st.reload == 24'h000001 && !I_WR)
        ##1 (!I_WR)[*2] |=> $past(zero_evt, 1) && !$past(zero_evt, 2))
        else $error("Period is not reload plus one clocks");

    AST_IRQ_RAISED: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (zero_evt && st.tick_int && st.irq_mask && !wr_msk) |=> O_IRQ)
        else $error("Interrupt not raised at zero");

    AST_NO_IRQ_DISABLED: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!st.irq_status && !(zero_evt && st.tick_int)) |=> !O_IRQ)
        else $error("Interrupt raised without cause");

    AST_SYS_CLOCK: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (st.enable && st.clk_sel && !wr_cvr && st.current != 24'h000000) |=> st.current != $past(st.current))
        else $error("System clock select does not count each cycle");

    AST_REF_CLOCK: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (cnt_tick && !st.clk_sel && !wr_csr) |=> !cnt_tick)
        else $error("Reference clock counts faster than half rate");

    AST_CVR_CLEARS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        wr_cvr |=> st.current == 24'h000000 && !st.count_flag)
        else $error("Current value write did not clear counter");

    AST_CSR_SEVEN: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (wr_csr && I_WDATA[2:0] == 3'h7) |=> st.enable && st.tick_int && st.clk_sel && cnt_tick)
        else $error("Writing 0x7 did not start system clock counting");

    AST_DISABLED_HOLDS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!st.enable && !wr_cvr && !wr_csr) |=> $stable(st.current))
        else $error("Disabled counter moved");

    AST_CALIB_KEEPS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !wr_cal |=> $stable(st.calib))
        else $error("Calibration changed without write");

    // ------------------------------------------------------------
    // Register port and sticky bit checks
    // ------------------------------------------------------------

    AST_RDATA_IDLE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !I_RD |=> O_RDATA == 32'h00000000)
        else $error("Read data not zero outside a read");

    AST_UNMAPPED_READ: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_RD && !rd_csr && !rd_sts && I_ADDR != ptdc_pkg::ADDR_RELOAD_VALUE
        && I_ADDR != ptdc_pkg::ADDR_CURRENT_VALUE && I_ADDR != ptdc_pkg::ADDR_CALIBRATION_VALUE
        && I_ADDR != ptdc_pkg::ADDR_IRQ_MASK) |=> O_RDATA == 32'h00000000)
        else $error("Unmapped read returned data");

    AST_RD_CONTROL: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        rd_csr |=> O_RDATA[ptdc_pkg::BIT_ENABLE] == $past(st.enable)
        && O_RDATA[ptdc_pkg::BIT_TICK_INT] == $past(st.tick_int) && O_RDATA[ptdc_pkg::BIT_CLK_SEL] == $past(st.clk_sel))
        else $error("Control read data wrong");

    AST_RD_RELOAD: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == ptdc_pkg::ADDR_RELOAD_VALUE) |=> O_RDATA == {8'h00, $past(st.reload)})
        else $error("Reload read data wrong");

    AST_RD_CURRENT: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == ptdc_pkg::ADDR_CURRENT_VALUE) |=> O_RDATA == {8'h00, $past(st.current)})
        else $error("Current value read data wrong");

    AST_RD_CALIB: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == ptdc_pkg::ADDR_CALIBRATION_VALUE) |=> O_RDATA == $past(st.calib))
        else $error("Calibration read data wrong");

    AST_RD_STATUS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        rd_sts |=> O_RDATA == {31'h00000000, $past(st.irq_status)})
        else $error("Status read data wrong");

    AST_RD_MASK: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == ptdc_pkg::ADDR_IRQ_MASK) |=> O_RDATA == {31'h00000000, $past(st.irq_mask)})
        else $error("Mask read data wrong");

    AST_RELOAD_WRITE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        wr_rvr |=> st.reload == $past(I_WDATA[ptdc_pkg::COUNT_W-1:0]))
        else $error("Reload write not taken");

    AST_RELOAD_KEEPS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !wr_rvr |=> $stable(st.reload))
        else $error("Reload changed without write");

    AST_CALIB_WRITE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        wr_cal |=> st.calib == $past(I_WDATA))
        else $error("Calibration write not taken");

    AST_MASK_WRITE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        wr_msk |=> st.irq_mask == $past(I_WDATA[ptdc_pkg::BIT_IRQ_ZERO]))
        else $error("Mask write not taken");

    AST_MASK_KEEPS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !wr_msk |=> $stable(st.irq_mask))
        else $error("Mask changed without write");

    AST_CTRL_WRITE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        wr_csr |=> st.enable == $past(I_WDATA[ptdc_pkg::BIT_ENABLE])
        && st.tick_int == $past(I_WDATA[ptdc_pkg::BIT_TICK_INT]) && st.clk_sel == $past(I_WDATA[ptdc_pkg::BIT_CLK_SEL]))
        else $error("Control write not taken");

    AST_CTRL_KEEPS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !wr_csr |=> $stable(st.enable) && $stable(st.tick_int) && $stable(st.clk_sel))
        else $error("Control bits changed without write");

    AST_STATUS_READ_CLEARS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (rd_sts && !(zero_evt && st.tick_int)) |=> !st.irq_status)
        else $error("Status read did not clear status");

    AST_STATUS_STICKY: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (st.irq_status && !rd_sts) |=> st.irq_status)
        else $error("Status dropped without read");

    AST_FLAG_STICKY: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (st.count_flag && !rd_csr && !wr_cvr) |=> st.count_flag)
        else $error("Count flag dropped without read");

    AST_FLAG_ONLY_AT_ZERO: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!st.count_flag && !zero_evt) |=> !st.count_flag)
        else $error("Count flag set without reaching zero");

    AST_STATUS_ONLY_AT_ZERO: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!st.irq_status && !zero_evt) |=> !st.irq_status)
        else $error("Status set without reaching zero");

    AST_IRQ_NEEDS_ENABLE: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (zero_evt && !st.tick_int && !st.irq_status) |=> !st.irq_status)
        else $error("Status set with interrupt disabled");

    AST_IRQ_FOLLOWS_MASK: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (st.irq_status && st.irq_mask && !rd_sts && !wr_msk) |=> O_IRQ)
        else $error("Unmasked status does not drive interrupt");

    AST_MASK_BLOCKS: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        (!st.irq_mask && !wr_msk) |=> !O_IRQ)
        else $error("Masked status drives interrupt");

    COV_ZERO: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
        zero_evt && st.clk_sel);
    COV_ZERO_REF: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
        zero_evt && !st.clk_sel);
    COV_IRQ_RISE: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
        $rose(O_IRQ));
    COV_SET_CLEAR_CLASH: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
        zero_evt && rd_csr);

endmodule : ptdc_top

// ===== dv/tb_top.sv
// Self-checking testbench of the periodic tick down counter
`timescale 1ns/1ns
module tb_top;
    // ------------------------------------------------------------
    // Design ports and bookkeeping
    // ------------------------------------------------------------
    logic I_MCLK = 1'b0;
    logic I_NRST = 1'b0;
    logic [31:0] I_ADDR = 32'h00000000;
    logic [31:0] I_WDATA = 32'h00000000;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic [31:0] O_RDATA;
    logic O_IRQ;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] smp [0:15];

    ptdc_top u_dut (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ));

    always #4 I_MCLK = ~I_MCLK;

    // ------------------------------------------------------------
    // Bus tasks and compare
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        I_WR <= 1'b1;
        I_ADDR <= addr;
        I_WDATA <= data;
        @(posedge I_MCLK);
        I_WR <= 1'b0;
        @(posedge I_MCLK);
    endtask : wr

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        I_RD <= 1'b1;
        I_ADDR <= addr;
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        #1 check(O_RDATA, exp);
        @(posedge I_MCLK);
    endtask : rd_chk

    // Back-to-back reads, one sample per cycle
    task automatic sample_current();
        I_RD <= 1'b1;
        I_ADDR <= ptdc_pkg::ADDR_CURRENT_VALUE;
        for (int i = 0; i < 16; i++) begin
            @(posedge I_MCLK);
            if (i == 15) begin
                I_RD <= 1'b0;
            end
            #1 smp[i] = O_RDATA;
        end
        @(posedge I_MCLK);
    endtask : sample_current

    function automatic logic [31:0] step(input logic [31:0] v, input logic [31:0] r);
        return (v == 32'h00000000) ? r : v - 32'h00000001;
    endfunction : step

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(32'(O_IRQ), 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_RELOAD_VALUE, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_CALIBRATION_VALUE, ptdc_pkg::RST_CALIBRATION);
        rd_chk(ptdc_pkg::ADDR_IRQ_MASK, 32'h00000001);
        rd_chk(ptdc_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    endtask : t_reset

    task automatic t_calib();
        wr(ptdc_pkg::ADDR_CALIBRATION_VALUE, 32'hA5A55A5A);
        rd_chk(ptdc_pkg::ADDR_CALIBRATION_VALUE, 32'hA5A55A5A);
        // Address 0xE000E01C, next to current value, is unmapped; calibration sits at 0x0E000E1C
        wr(32'hE000E01C, 32'hFFFFFFFF);
        rd_chk(32'hE000E01C, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_CALIBRATION_VALUE, 32'hA5A55A5A);
    endtask : t_calib

    task automatic t_count(input logic [31:0] ctl, input logic [31:0] rld);
        wr(ptdc_pkg::ADDR_RELOAD_VALUE, 32'hFF000000 | rld);
        rd_chk(ptdc_pkg::ADDR_RELOAD_VALUE, rld);
        wr(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00000123);
        rd_chk(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00000000);
        wr(ptdc_pkg::ADDR_CONTROL_STATUS, ctl);
        sample_current();
        for (int i = 2; i < 16; i++) begin
            check(smp[i], ctl[2] ? step(smp[i-1], rld) : step(smp[i-2], rld));
        end
        check(32'(O_IRQ), 32'(ctl[1]));
        wr(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00010000);
        rd_chk(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_IRQ_STATUS, 32'(ctl[1]));
        check(32'(O_IRQ), 32'h00000000);
    endtask : t_count

    task automatic t_mask();
        wr(ptdc_pkg::ADDR_IRQ_MASK, 32'h00000000);
        wr(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00000000);
        wr(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00000007);
        repeat (12) @(posedge I_MCLK);
        check(32'(O_IRQ), 32'h00000000);
        wr(ptdc_pkg::ADDR_IRQ_MASK, 32'h00000001);
        check(32'(O_IRQ), 32'h00000001);
        // Clear while counting: zero, then reload on the next tick
        wr(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00FFFFFF);
        rd_chk(ptdc_pkg::ADDR_CURRENT_VALUE, 32'h00000003);
        wr(ptdc_pkg::ADDR_CONTROL_STATUS, 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_IRQ_STATUS, 32'h00000001);
        check(32'(O_IRQ), 32'h00000000);
        rd_chk(ptdc_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    endtask : t_mask

    // ------------------------------------------------------------
    // Verdict, sequence and watchdog
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge I_MCLK);
        I_NRST <= 1'b1;
        @(posedge I_MCLK);
        t_reset();
        t_calib();
        t_count(32'h00000005, 32'h00000001);
        t_count(32'h00000007, 32'h00000003);
        t_count(32'h00000003, 32'h00000003);
        t_mask();
        end_of_test();
    end

    initial begin
        #(8 * 5000);
        num_errors++;
        end_of_test();
    end
endmodule : tb_top
